// ==== src/flash_seq_pkg.sv ====
// Shared constants of the flash command sequencer and its host end.
// Assumes a 100 MHz system clock; all counts are in its cycles.
package flash_seq_pkg;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int ERASE_WINDOW_US = 35;
  localparam int ERASE_WINDOW_CYC = ERASE_WINDOW_US * CLK_MHZ;
  localparam int PROG_TIME_CYC = 64;
  localparam int TIME_LIMIT_CYC = 8192;
  // Unlock addresses, low 16 address bits
  localparam logic [15:0] UNLOCK_ADDR1 = 16'h1550;
  localparam logic [15:0] UNLOCK_ADDR2 = 16'h0aa8;
  // Command codes, low data byte
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'ha0;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECTOR = 8'h30;
  localparam logic [7:0] CODE_RESTART = CODE_SECTOR;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [15:0] ERASED_HALF = 16'hffff;
  // Status word bit positions
  localparam int BIT_DATA_POLL = 7;
  localparam int BIT_RUN_TOGGLE = 6;
  localparam int BIT_TIME_LIMIT = 5;
  localparam int BIT_ERASE_WINDOW = 3;
  localparam int BIT_SUSPEND_TOGGLE = 2;
  // Access sizes on the link
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // Host register offsets and fields
  localparam logic [7:0] REG_CMD_ADDR = 8'h00;
  localparam logic [7:0] REG_CMD_DATA = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_READ_DATA = 8'h10;
  localparam int CTRL_PROG_MODE = 0;
  localparam int CTRL_GO_WRITE = 1;
  localparam int CTRL_GO_READ = 2;
  localparam int CTRL_SIZE_LSB = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_ODD = 2;
  localparam int STAT_DISCARD = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== src/flash_link_if.sv ====
// Link between the bus master end and the flash sequencer end.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none
interface flash_link_if;
  logic req;
  logic we;
  logic [1:0] size;
  logic [31:0] addr;
  logic [15:0] wdata;
  logic prog_mode;
  logic [31:0] rdata;
  logic ack;
  logic ready;
  modport device (input req, we, size, addr, wdata, prog_mode, output rdata, ack, ready);
  modport host (output req, we, size, addr, wdata, prog_mode, input rdata, ack, ready);
endinterface
`default_nettype wire

// ==== src/flash_command_sequencer.sv ====
// Flash array with its command decoder and automatic algorithm status.
// Assumes the host holds req until ack and runs on CLK_SYS.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer #(
  parameter int SECTOR_COUNT = 8,
  parameter int SECTOR_HALFWORDS = 512,
  parameter logic [31:0] FLASH_BASE = 32'h0,
  parameter int PROG_CYCLES = flash_seq_pkg::PROG_TIME_CYC,
  parameter int LIMIT_CYCLES = flash_seq_pkg::TIME_LIMIT_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Link to the bus master
  flash_link_if.device LINK,
  // Algorithm state for the user side
  output var logic ALGO_RUNNING,
  output var logic TIME_LIMIT_HIT
);
  import flash_seq_pkg::*;

  localparam int WORDS = SECTOR_COUNT * SECTOR_HALFWORDS;
  localparam int AW = $clog2(WORDS);
  localparam int SW = $clog2(SECTOR_COUNT);
  localparam logic [31:0] BYTES = 32'(2 * WORDS);

  // Shapes the logic cannot serve
  generate
    if (SECTOR_COUNT < 2 || (SECTOR_COUNT & (SECTOR_COUNT - 1)) != 0 ||
        SECTOR_HALFWORDS < 2 || (SECTOR_HALFWORDS & (SECTOR_HALFWORDS - 1)) != 0 ||
        WORDS > 32768 || 2 * WORDS <= int'(UNLOCK_ADDR1) || PROG_CYCLES < 1 ||
        LIMIT_CYCLES <= WORDS || LIMIT_CYCLES <= PROG_CYCLES) begin : g_bad
      $error("flash_command_sequencer: unsupported parameters");
    end
  endgenerate

  typedef enum logic [2:0] {ST_READ, ST_PROG, ST_CHIP, ST_SE_WIN, ST_SE_RUN, ST_SUSP} algo_t;

  typedef struct packed {
    algo_t state;
    logic [2:0] seq;
    logic [AW-1:0] prog_idx;
    logic [15:0] prog_data;
    logic locked;
    logic [15:0] cnt;
    logic [31:0] timer;
    logic [SECTOR_COUNT-1:0] marked;
    logic time_limit_flag;
    logic tog1;
    logic tog2;
    logic ack;
    logic [31:0] rdata;
  } seq_state_t;

  seq_state_t r;
  seq_state_t n;
  logic [15:0] mem [WORDS];
  logic [31:0] offset;
  logic in_range;
  logic [AW-1:0] idx;
  logic [SW-1:0] sec;
  logic [SW-1:0] csec;
  logic [15:0] rd_lo;
  logic [15:0] rd_hi;
  logic [15:0] prog_old;
  logic [7:0] code;
  logic at1;
  logic at2;
  logic take;
  logic cmd_ok;
  logic running;
  logic show;
  logic [15:0] status;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [15:0] mem_wd;

  // Address decode and array read ports
  assign offset = LINK.addr - FLASH_BASE;
  assign in_range = offset < BYTES;
  assign idx = offset[AW:1];
  assign sec = idx[AW-1 -: SW];
  assign csec = r.cnt[AW-1 -: SW];
  assign rd_lo = mem[idx];
  assign rd_hi = mem[AW'(idx + 1'b1)];
  assign prog_old = mem[r.prog_idx];
  assign code = LINK.wdata[7:0];
  assign at1 = LINK.addr[15:0] == UNLOCK_ADDR1;
  assign at2 = LINK.addr[15:0] == UNLOCK_ADDR2;
  assign take = LINK.req && !r.ack;
  // Commands only count as half-word writes in programming mode
  assign cmd_ok = LINK.prog_mode && LINK.size == SIZE_HALF && in_range;
  assign running = r.state == ST_PROG || r.state == ST_CHIP || r.state == ST_SE_RUN;
  // Suspended reads outside the erase sectors see plain data
  assign show = LINK.prog_mode && LINK.size != SIZE_WORD && r.state != ST_READ &&
                (r.state != ST_SUSP || r.marked[sec]);

  // Next state: algorithm progress, then command writes, then reads
  always_comb begin
    n = r;
    n.ack = take;
    mem_we = 1'b0;
    mem_wa = r.prog_idx;
    mem_wd = prog_old & r.prog_data;
    status = 16'h0;
    // Overrun timer; it stops once the flag is up
    if (running && !r.time_limit_flag) begin
      n.timer = r.timer + 32'h1;
      if (r.timer == 32'(LIMIT_CYCLES - 1)) begin
        n.time_limit_flag = 1'b1;
      end
    end
    case (r.state)
      ST_PROG: begin
        n.cnt = r.cnt + 16'h1;
        // A program that needs a 0 turned to 1 never finishes
        if (!r.locked && r.cnt == 16'(PROG_CYCLES - 1)) begin
          mem_we = 1'b1;
          n.state = ST_READ;
        end
      end
      ST_SE_WIN: begin
        n.cnt = r.cnt + 16'h1;
        if (r.cnt == 16'(ERASE_WINDOW_CYC - 1)) begin
          n.state = ST_SE_RUN;
          n.cnt = 16'h0;
        end
      end
      ST_CHIP, ST_SE_RUN: begin
        // One half-word per cycle, only in marked sectors
        mem_wa = r.cnt[AW-1:0];
        mem_wd = ERASED_HALF;
        mem_we = r.marked[csec];
        n.cnt = r.cnt + 16'h1;
        if (r.cnt == 16'(WORDS - 1)) begin
          n.state = ST_READ;
          n.marked = '0;
        end
      end
      default: ;
    endcase
    if (take && LINK.we && cmd_ok) begin
      if (r.time_limit_flag) begin
        // Only the reset code leaves an overrun
        if (code == CODE_RESET) begin
          n.state = ST_READ;
          n.time_limit_flag = 1'b0;
          n.marked = '0;
          n.seq = 3'h0;
        end
      end else begin
        case (r.state)
          ST_READ: begin
            n.seq = 3'h0; // A stray or reset write keeps read state
            case (r.seq)
              3'h0: if (at1 && code == CODE_UNLOCK1) n.seq = 3'h1;
              3'h1: if (at2 && code == CODE_UNLOCK2) n.seq = 3'h2;
              3'h2: begin
                if (at1 && code == CODE_PROGRAM) n.seq = 3'h3;
                else if (at1 && code == CODE_ERASE) n.seq = 3'h4;
              end
              3'h3: begin
                // Odd data address is not a program
                if (!LINK.addr[0]) begin
                  n.state = ST_PROG;
                  n.prog_idx = idx;
                  n.prog_data = LINK.wdata;
                  n.locked = |(LINK.wdata & ~rd_lo);
                  n.cnt = 16'h0;
                  n.timer = 32'h0;
                end
              end
              3'h4: if (at1 && code == CODE_UNLOCK1) n.seq = 3'h5;
              3'h5: if (at2 && code == CODE_UNLOCK2) n.seq = 3'h6;
              3'h6: begin
                n.cnt = 16'h0;
                n.timer = 32'h0;
                if (at1 && code == CODE_CHIP) begin
                  n.state = ST_CHIP;
                  n.marked = '1;
                end else if (code == CODE_SECTOR) begin
                  n.state = ST_SE_WIN;
                  n.marked = '0;
                  n.marked[sec] = 1'b1;
                end
              end
              default: ;
            endcase
          end
          ST_SE_WIN: begin
            if (code == CODE_SECTOR) begin
              n.marked[sec] = 1'b1;
            end else if (code == CODE_SUSPEND) begin
              n.state = ST_SUSP;
              n.cnt = 16'h0;
            end
          end
          // Restart code is ignored while erasing
          ST_SE_RUN: if (code == CODE_SUSPEND) n.state = ST_SUSP;
          ST_SUSP: if (code == CODE_RESTART) n.state = ST_SE_RUN;
          default: ; // Program and chip erase ignore suspend
        endcase
      end
    end
    if (take && !LINK.we) begin
      n.rdata = (LINK.size == SIZE_WORD) ? {rd_hi, rd_lo} : {16'h0, rd_lo};
      if (show) begin
        case (r.state)
          ST_PROG: begin
            status[BIT_DATA_POLL] = ~r.prog_data[BIT_DATA_POLL];
            status[BIT_RUN_TOGGLE] = r.tog1;
            n.tog1 = ~r.tog1;
          end
          ST_SUSP: begin
            status[BIT_ERASE_WINDOW] = 1'b1;
            status[BIT_SUSPEND_TOGGLE] = r.tog2;
            n.tog2 = ~r.tog2;
          end
          default: begin
            // Polling bit stays 0 while erasing
            status[BIT_RUN_TOGGLE] = r.tog1;
            status[BIT_SUSPEND_TOGGLE] = r.tog2;
            status[BIT_ERASE_WINDOW] = r.state != ST_SE_WIN;
            n.tog1 = ~r.tog1;
            n.tog2 = ~r.tog2;
          end
        endcase
        status[BIT_TIME_LIMIT] = r.time_limit_flag;
        n.rdata = {16'h0, status}; // Undefined bits read 0
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Array storage, no reset: contents survive reset like real cells
  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Outputs
  assign LINK.ack = r.ack;
  assign LINK.rdata = r.rdata;
  assign LINK.ready = r.state == ST_READ;
  assign ALGO_RUNNING = r.state != ST_READ;
  assign TIME_LIMIT_HIT = r.time_limit_flag;
endmodule // flash_command_sequencer
`default_nettype wire

// ==== src/flash_host_master.sv ====
// Bus master end: AXI4-Lite registers turned into flash link accesses.
// Assumes the flash end acks each request one cycle after taking it.
`timescale 1ns/1ns
`default_nettype none
module flash_host_master (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // AXI4-Lite write channels
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read channels
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Link to the flash
  flash_link_if.host LINK
);
  import flash_seq_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] cmd_addr;
    logic [15:0] cmd_data;
    logic prog_mode;
    logic [1:0] size;
    logic busy;
    logic req;
    logic we;
    logic [1:0] lsize;
    logic [31:0] read_data;
    logic fresh;
    logic odd_warn;
    logic discarded;
  } host_state_t;

  host_state_t r;
  host_state_t n;
  logic [31:0] merged;
  logic go_w;
  logic go_r;

  // Byte-lane merge of the pending write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = nv[8*i +: 8];
    end
    return res;
  endfunction

  assign go_w = r.wdata[CTRL_GO_WRITE];
  assign go_r = r.wdata[CTRL_GO_READ];

  always_comb begin
    n = r;
    merged = 32'h0;
    // Address and data are taken in either order
    if (AWVALID && AWREADY) begin
      n.aw_got = 1'b1;
      n.awaddr = AWADDR;
    end
    if (WVALID && WREADY) begin
      n.w_got = 1'b1;
      n.wdata = WDATA;
      n.wstrb = WSTRB;
    end
    if (r.bvalid && BREADY) n.bvalid = 1'b0;
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.awaddr)
        REG_CMD_ADDR: n.cmd_addr = merge(r.cmd_addr, r.wdata, r.wstrb);
        REG_CMD_DATA: begin
          merged = merge({16'h0, r.cmd_data}, r.wdata, r.wstrb);
          n.cmd_data = merged[15:0];
        end
        REG_CTRL: begin
          if (r.wstrb[0]) begin
            n.prog_mode = r.wdata[CTRL_PROG_MODE];
            n.size = r.wdata[CTRL_SIZE_LSB +: 2];
            // A go while busy is dropped; software polls busy first
            if (!r.busy && (go_w || go_r)) begin
              n.busy = 1'b1;
              n.req = 1'b1;
              n.we = go_w; // One write per go
              n.lsize = r.wdata[CTRL_SIZE_LSB +: 2];
              n.discarded = 1'b0;
              if (go_w && r.wdata[CTRL_SIZE_LSB +: 2] == SIZE_HALF && r.cmd_addr[0]) begin
                n.odd_warn = 1'b1;
              end
              // Status cannot come back on a word read
              if (!go_w && !LINK.ready && r.wdata[CTRL_SIZE_LSB +: 2] == SIZE_WORD) begin
                n.lsize = SIZE_HALF;
              end
            end
          end
        end
        REG_STATUS: n.odd_warn = 1'b0;
        REG_READ_DATA: ;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // Link engine
    if (r.req && LINK.ack) begin
      if (r.we) begin
        n.req = 1'b0;
        n.busy = 1'b0;
        n.fresh = 1'b1;
      end else if (r.fresh) begin
        // Keep req up: the same read goes out again
        n.fresh = 1'b0;
        n.discarded = 1'b1;
      end else begin
        n.req = 1'b0;
        n.busy = 1'b0;
        n.read_data = LINK.rdata;
      end
    end
    // Register reads
    if (r.rvalid && RREADY) n.rvalid = 1'b0;
    if (ARVALID && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0;
      case (ARADDR)
        REG_CMD_ADDR: n.rdata = r.cmd_addr;
        REG_CMD_DATA: n.rdata = {16'h0, r.cmd_data};
        REG_CTRL: begin
          n.rdata[CTRL_PROG_MODE] = r.prog_mode;
          n.rdata[CTRL_SIZE_LSB +: 2] = r.size;
        end
        REG_STATUS: begin
          n.rdata[STAT_BUSY] = r.busy;
          n.rdata[STAT_READY] = LINK.ready;
          n.rdata[STAT_ODD] = r.odd_warn;
          n.rdata[STAT_DISCARD] = r.discarded;
        end
        REG_READ_DATA: n.rdata = r.read_data;
        default: n.rresp = RESP_SLVERR;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Handshakes and outputs
  assign AWREADY = !r.aw_got && !r.bvalid;
  assign WREADY = !r.w_got && !r.bvalid;
  assign BVALID = r.bvalid;
  assign BRESP = r.bresp;
  assign ARREADY = !r.rvalid;
  assign RVALID = r.rvalid;
  assign RDATA = r.rdata;
  assign RRESP = r.rresp;
  assign LINK.req = r.req;
  assign LINK.we = r.we;
  assign LINK.size = r.lsize;
  assign LINK.addr = r.cmd_addr;
  assign LINK.wdata = r.cmd_data;
  assign LINK.prog_mode = r.prog_mode;
endmodule // flash_host_master
`default_nettype wire

// ==== verification/flash_link_props.sv ====
// Checker for the link that joins the host end to the flash sequencer end.
// Assumes it is instantiated beside the link interface and runs on CLK_SYS.
`timescale 1ns/1ns
`default_nettype none
module flash_link_props
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Link signals
  input wire logic req,
  input wire logic we,
  input wire logic [1:0] size,
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  input wire logic prog_mode,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic ready
);
  typedef struct packed {
    logic wrote;
  } chk_state_t;
  chk_state_t st;
  chk_state_t next_st;
  logic take;
  logic cmd_take;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Request seen by the device; only half-word writes in programming mode can start work
  assign take = req && !ack;
  assign cmd_take = take && we && prog_mode && (size == SIZE_HALF);
  // Remember whether the last acked transfer was a write
  always_comb begin
    next_st = st;
    if (ack) begin
      next_st.wrote = we;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    st <= RST_N ? next_st : '0;
  end
  AST_ACK_AFTER_TAKE: assert property (take |=> ack)
    else $error("link request not acked one cycle after take");
  AST_ACK_HAS_CAUSE: assert property (ack |-> $past(take))
    else $error("link ack without a pending request");
  AST_REQ_HOLDS: assert property (take |=> req && $stable(we))
    else $error("link request changed before ack");
  AST_WRITE_RELEASE: assert property (ack && we |=> !req)
    else $error("write request not released after ack");
  AST_DISCARD_REISSUE: assert property (ack && !we && st.wrote |=> req && !we)
    else $error("first read after a write not reissued");
  AST_READ_RELEASE: assert property (ack && !we && !st.wrote |=> !req)
    else $error("later read not released after ack");
  AST_RDATA_HOLD: assert property (!(ack && !we) |-> $stable(rdata))
    else $error("read data changed outside a read ack");
  AST_READY_FALL_CAUSE: assert property ($fell(ready) |-> $past(cmd_take) || $past(cmd_take, 2))
    else $error("ready fell without a command write");
  AST_READY_AT_RELEASE: assert property ($rose(RST_N) |-> ready && !ack)
    else $error("sequencer not idle after reset");
endmodule // flash_link_props
`default_nettype wire

// ==== verification/tb_flash_command_sequencer.sv ====
// Testbench: host end and sequencer joined by the link, driven over AXI4-Lite.
// Assumes default geometry: eight sectors of 1 KB starting at address 0.
`timescale 1ns/1ns
`default_nettype none
module tb_flash_command_sequencer;
  import flash_seq_pkg::*;
  localparam logic [31:0] DATA = 32'h0000ffff;
  localparam logic [31:0] NOTOG = 32'hffffffbb;
  localparam logic [31:0] NOT6 = 32'hffffffbf;
  localparam logic [31:0] NOT2 = 32'hfffffffb;
  logic clk_sys, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, algo_running, time_limit_hit;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, w;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [31:0] pa [4];
  logic [15:0] pd [4];
  int errors, samples_checked, n;
  flash_link_if i_flash_link_if ();
  flash_host_master i_flash_host_master (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
    .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
    .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
    .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .LINK(i_flash_link_if));
  flash_command_sequencer i_flash_command_sequencer (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .LINK(i_flash_link_if), .ALGO_RUNNING(algo_running), .TIME_LIMIT_HIT(time_limit_hit));
  flash_link_props i_flash_link_props (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .req(i_flash_link_if.req), .we(i_flash_link_if.we), .size(i_flash_link_if.size),
    .addr(i_flash_link_if.addr), .wdata(i_flash_link_if.wdata),
    .prog_mode(i_flash_link_if.prog_mode), .rdata(i_flash_link_if.rdata),
    .ack(i_flash_link_if.ack), .ready(i_flash_link_if.ready));
  // Compare helpers
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // A wait that ran out of its bound ends the run
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      check_word("wait_bound", 32'h0, 32'(k));
      test_done;
    end
  endtask
  // Expected status word and control byte
  function automatic logic [31:0] flags(input logic p, t, l, e, s);
    return {24'h0, p, t, l, 1'b0, e, s, 2'h0};
  endfunction
  function automatic logic [7:0] ctl(input logic pm, input logic rd_go);
    return {2'h0, SIZE_HALF, 1'b0, rd_go, ~rd_go, pm};
  endfunction
  // AXI4-Lite write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int k;
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    bound(k, 50);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int k;
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    bound(k, 50);
  endtask
  // One link transfer through the host registers, waiting out busy
  task automatic link_op(input logic [31:0] a, input logic [15:0] d, input logic [7:0] c,
                         output logic [31:0] q);
    int k;
    axi_wr(REG_CMD_ADDR, a, r);
    axi_wr(REG_CMD_DATA, {16'h0, d}, r);
    axi_wr(REG_CTRL, {24'h0, c}, r);
    for (k = 0; k < 50; k++) begin
      axi_rd(REG_STATUS, q, r);
      if (q[STAT_BUSY] === 1'b0) break;
    end
    bound(k, 50);
    axi_rd(REG_READ_DATA, q, r);
  endtask
  // Upper data byte is random: the decoder must look at the low byte only
  task automatic cmd(input logic [31:0] a, input logic [7:0] code);
    link_op(a, {8'($urandom), code}, ctl(1'b1, 1'b0), w);
  endtask
  task automatic rd(input logic [31:0] a, input logic pm, output logic [31:0] q);
    link_op(a, 16'h0, ctl(pm, 1'b1), q);
  endtask
  task automatic unlock(input logic [7:0] code);
    cmd(32'(UNLOCK_ADDR1), CODE_UNLOCK1);
    cmd(32'(UNLOCK_ADDR2), CODE_UNLOCK2);
    cmd(32'(UNLOCK_ADDR1), code);
  endtask
  task automatic erase(input logic [31:0] a, input logic [7:0] code);
    unlock(CODE_ERASE);
    cmd(32'(UNLOCK_ADDR1), CODE_UNLOCK1);
    cmd(32'(UNLOCK_ADDR2), CODE_UNLOCK2);
    cmd(a, code);
  endtask
  task automatic prog(input logic [31:0] a, input logic [15:0] d);
    unlock(CODE_PROGRAM);
    link_op(a, d, ctl(1'b1, 1'b0), w);
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 4000; k++) begin
      axi_rd(REG_STATUS, v, r);
      if (v[STAT_READY] === 1'b1) break;
    end
    bound(k, 4000);
  endtask
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    errors = 0;
    samples_checked = 0;
    void'($urandom(51201));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    axi_rd(REG_STATUS, v, r);
    check_word("status_idle", 32'h2, v);
    check_resp("rresp_status", RESP_OKAY, r);
    axi_wr(8'h40, 32'h1, r);
    check_resp("bresp_unmapped", RESP_SLVERR, r);
    // Chip erase; suspend must be ignored during it
    erase(32'(UNLOCK_ADDR1), CODE_CHIP);
    rd(32'h0, 1'b1, v);
    rd(32'h0, 1'b1, w);
    check_word("chip_flags", flags(0, 0, 0, 1, 0), v & NOTOG);
    check_word("chip_toggle", {31'h0, ~v[6]}, {31'h0, w[6]});
    // Word-sized read while busy: host must fall back to half size
    link_op(32'h0, 16'h0, 8'h25, v);
    check_word("word_status", flags(0, 0, 0, 1, 0), v & NOTOG);
    check_word("running_pin", 32'h2, {30'h0, algo_running, time_limit_hit});
    cmd(32'h0, CODE_SUSPEND);
    rd(32'h400, 1'b1, v);
    check_word("chip_no_suspend", flags(0, 0, 0, 1, 0), v & NOTOG);
    wait_ready;
    for (int s = 0; s < 8; s++) begin
      rd(32'(s * 1024 + 2 * ($urandom % 512)), 1'b1, v);
      check_word("chip_erased", 32'(ERASED_HALF), v & DATA);
    end
    // Read-only word read returns two array half-words
    link_op(32'h0, 16'h0, 8'h24, v);
    check_word("rom_word", {ERASED_HALF, ERASED_HALF}, v);
    // Random programs in even sectors; bit 0 kept clear for the overrun case
    for (int i = 0; i < 4; i++) begin
      pa[i] = 32'(i * 2048 + 2 * ($urandom % 512));
      pd[i] = 16'($urandom) & 16'hfffe;
      prog(pa[i], pd[i]);
      rd(pa[i], 1'b1, v);
      check_word("prog_flags", flags(~pd[i][7], 0, 0, 0, 0), v & NOT6);
      wait_ready;
      rd(pa[i], 1'b1, v);
      check_word("prog_data", {16'h0, pd[i]}, v & DATA);
      rd(pa[i] + 2, 1'b1, v);
      check_word("prog_single", 32'(ERASED_HALF), v & DATA);
    end
    prog(pa[0] + 1, 16'h0);
    axi_rd(REG_STATUS, v, r);
    check_word("odd_warn", 32'h6, v & 32'h6);
    axi_wr(REG_STATUS, 32'h0, r);
    axi_rd(REG_STATUS, v, r);
    check_word("odd_clear", 32'h2, v & 32'h6);
    rd(pa[0], 1'b1, v);
    check_word("odd_data", {16'h0, pd[0]}, v & DATA);
    // Sector erase of two sectors, read-only read, suspend and restart
    erase(pa[1], CODE_SECTOR);
    cmd(pa[2], CODE_SECTOR);
    rd(pa[1], 1'b1, v);
    check_word("window_flags", flags(0, 0, 0, 0, 0), v & NOTOG);
    rd(pa[0], 1'b0, v);
    check_word("rom_read", {16'h0, pd[0]}, v & DATA);
    cmd(pa[0], CODE_SUSPEND);
    rd(pa[1], 1'b1, v);
    check_word("susp_marked", flags(0, 0, 0, 1, 0), v & NOT2);
    rd(pa[3], 1'b1, v);
    check_word("susp_other", {16'h0, pd[3]}, v & DATA);
    cmd(pa[0], CODE_RESTART);
    for (n = 0; n < 400; n++) begin
      rd(pa[1], 1'b1, v);
      if (v[BIT_ERASE_WINDOW] === 1'b1) break;
    end
    bound(n, 400);
    cmd(pa[0], CODE_RESTART);
    rd(pa[1], 1'b1, v);
    check_word("restart_ignored", flags(0, 0, 0, 1, 0), v & NOTOG);
    wait_ready;
    for (int i = 0; i < 4; i++) begin
      rd(pa[i], 1'b1, v);
      w = (i == 1 || i == 2) ? 32'(ERASED_HALF) : {16'h0, pd[i]};
      check_word("sector_erase", w, v & DATA);
    end
    // Program needing 0 to 1 overruns; reset code brings back read state
    prog(pa[3], ERASED_HALF);
    for (n = 0; n < 600; n++) begin
      rd(pa[3], 1'b1, v);
      if (v[BIT_TIME_LIMIT] === 1'b1) break;
    end
    bound(n, 600);
    check_word("limit_flags", flags(0, 0, 1, 0, 0), v & NOT6);
    check_word("limit_pins", 32'h3, {30'h0, algo_running, time_limit_hit});
    cmd(pa[0], CODE_RESET);
    wait_ready;
    rd(pa[3], 1'b1, v);
    check_word("after_reset_cmd", {16'h0, pd[3]}, v & DATA);
    check_word("idle_pins", 32'h0, {30'h0, algo_running, time_limit_hit});
    test_done;
  end
endmodule // tb_flash_command_sequencer
`default_nettype wire
